// [hw/tport_top.sv]
// dual 8-bit counter timer with six 3-state outputs and serial shifter
//
// Overview of operation
// - Two independent 8-bit counters exist, and one pin input can trigger the low counter.
// - Six output lines are each driven high, low or left floating under software control.
// - Each counter picks its clock from an external pin, the auxiliary clock or the master clock.
// - The low counter can be halted, run freely, or be gated by one of two chosen pins.
// - In a gated mode the gate event sets the shared interrupt flag and stops the counter.
// - Software can read both counter values and write either one at any time.
// - The two counters can be cascaded into one 16-bit counter.
// - In split mode the gate, low overflow or high overflow each raise the shared interrupt.
// - In cascaded mode the gate, the overflow of the full 16-bit value or the last serial bit raise it, not the low overflow.
// - A serial bit stream is shifted out one bit per low-counter overflow period.
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/10ps
module tport_top
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // register port
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // internal clock enables, one cycle pulses from the same clock
  input wire logic aclk_tick_i,
  input wire logic mclk_tick_i,
  // pins
  input wire logic ext_lo_i,
  input wire logic ext_hi_i,
  input wire logic gate_a_i,
  input wire logic gate_b_i,
  output logic [5:0] port_o,
  output logic [5:0] port_oe_o,
  output logic ser_o,
  // interrupt
  output logic irq_o
);
  tport_pkg::bus_req_s req;
  tport_pkg::pin_in_s lvl;
  tport_pkg::pin_in_s rise;

  logic [7:0] ctrl, next_ctrl;
  logic [7:0] cnt_lo, next_cnt_lo;
  logic [7:0] cnt_hi, next_cnt_hi;
  logic [5:0] port, next_port;
  logic [5:0] port_oe, next_port_oe;
  logic [3:0] stat, next_stat;
  logic [3:0] mask, next_mask;
  logic [7:0] rdata, next_rdata;
  logic irq, next_irq;
  logic [7:0] ser_sh, next_ser_sh;
  logic [3:0] ser_left, next_ser_left;
  logic ser, next_ser;
  logic [7:0] baud, next_baud;

  logic tick_lo, tick_hi, run_lo, ovf_lo, ovf_hi, ovf_16;
  logic [3:0] ev;

  function automatic logic pick_tick(input logic [1:0] sel, input logic ext,
                                     input logic ac, input logic mc);
    case (sel)
      tport_pkg::SRC_EXT: pick_tick = ext;
      tport_pkg::SRC_ACLK: pick_tick = ac;
      tport_pkg::SRC_MCLK: pick_tick = mc;
      default: pick_tick = 1'b0;
    endcase
  endfunction

  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  // pin inputs cross into this clock; count on rises, gate on filtered level
  tport_sync u_sync_ext_lo (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .pin_i(ext_lo_i),
    .level_o(lvl.ext_lo), .rise_o(rise.ext_lo));
  tport_sync u_sync_ext_hi (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .pin_i(ext_hi_i),
    .level_o(lvl.ext_hi), .rise_o(rise.ext_hi));
  tport_sync u_sync_gate_a (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .pin_i(gate_a_i),
    .level_o(lvl.gate_a), .rise_o(rise.gate_a));
  tport_sync u_sync_gate_b (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .pin_i(gate_b_i),
    .level_o(lvl.gate_b), .rise_o(rise.gate_b));

  always_comb
  begin
    tick_lo = pick_tick(ctrl[tport_pkg::CTRL_SEL_LO +: 2], rise.ext_lo,
                        aclk_tick_i, mclk_tick_i);
    tick_hi = pick_tick(ctrl[tport_pkg::CTRL_SEL_HI +: 2], rise.ext_hi,
                        aclk_tick_i, mclk_tick_i);
    // gated modes count while the chosen pin is high; its fall is the gate event
    case (ctrl[tport_pkg::CTRL_RUN +: 2])
      tport_pkg::RUN_HALT:
      begin
        run_lo = 1'b0;
      end
      tport_pkg::RUN_CONT:
      begin
        run_lo = 1'b1;
      end
      tport_pkg::RUN_GATE_A:
      begin
        run_lo = lvl.gate_a;
      end
      default:
      begin
        run_lo = lvl.gate_b;
      end
    endcase
  end

  // falling edge of the selected gate level, tracked locally
  logic gate_lvl, gate_prev, next_gate_prev;
  logic gate_mode;
  assign gate_mode = ctrl[tport_pkg::CTRL_RUN + 1];
  assign gate_lvl = ctrl[tport_pkg::CTRL_RUN] ? lvl.gate_b : lvl.gate_a;
  logic gate_fall;
  assign gate_fall = gate_mode & gate_prev & ~gate_lvl;

  always_comb
  begin
    next_gate_prev = gate_lvl;
    ovf_lo = tick_lo & run_lo & (cnt_lo == tport_pkg::CNT_MAX);
    ovf_16 = ovf_lo & (cnt_hi == tport_pkg::CNT_MAX);
    ovf_hi = tick_hi & ctrl[tport_pkg::CTRL_HI_EN] & (cnt_hi == tport_pkg::CNT_MAX);
    ev = 4'h0;
    ev[tport_pkg::ST_GATE] = gate_fall;
    if (ctrl[tport_pkg::CTRL_CASC])
      ev[tport_pkg::ST_OVF_HI] = ovf_16;
    else
    begin
      ev[tport_pkg::ST_OVF_LO] = ovf_lo;
      ev[tport_pkg::ST_OVF_HI] = ovf_hi;
    end
    ev[tport_pkg::ST_SER] = ovf_lo & (ser_left == 4'h1);
  end

  always_comb
  begin
    next_ctrl = ctrl;
    next_cnt_lo = cnt_lo;
    next_cnt_hi = cnt_hi;
    next_port = port;
    next_port_oe = port_oe;
    next_mask = mask;
    next_baud = baud;
    next_ser_sh = ser_sh;
    next_ser_left = ser_left;
    next_ser = ser;
    // counting
    if (tick_lo & run_lo)
      next_cnt_lo = ovf_lo ? baud : cnt_lo + 8'h01;
    if (ctrl[tport_pkg::CTRL_CASC])
    begin
      if (ovf_lo)
        next_cnt_hi = cnt_hi + 8'h01;
    end
    else if (tick_hi & ctrl[tport_pkg::CTRL_HI_EN])
      next_cnt_hi = cnt_hi + 8'h01;
    // gate event stops the counter by falling back to halt
    if (gate_fall)
      next_ctrl[tport_pkg::CTRL_RUN +: 2] = tport_pkg::RUN_HALT;
    // serial shifter: one bit per low-counter period
    if (ovf_lo && ser_left != 4'h0)
    begin
      next_ser = ser_sh[0];
      next_ser_sh = {1'b0, ser_sh[7:1]};
      next_ser_left = ser_left - 4'h1;
    end
    // software writes win over counting
    if (req.wr)
    begin
      case (req.addr)
        tport_pkg::OFS_CTRL: next_ctrl = req.wdata;
        tport_pkg::OFS_CNT_LO: next_cnt_lo = req.wdata;
        tport_pkg::OFS_CNT_HI: next_cnt_hi = req.wdata;
        tport_pkg::OFS_OUT: next_port = req.wdata[5:0];
        tport_pkg::OFS_OE: next_port_oe = req.wdata[5:0];
        tport_pkg::OFS_MASK: next_mask = req.wdata[3:0];
        tport_pkg::OFS_SER:
        begin
          next_ser_sh = req.wdata;
          next_ser_left = tport_pkg::SER_BITS;
        end
        tport_pkg::OFS_BAUD: next_baud = req.wdata;
        default: next_ctrl = next_ctrl;
      endcase
    end
    // sticky status: set wins over write-one-to-clear
    next_stat = stat;
    if (req.wr && req.addr == tport_pkg::OFS_STAT)
      next_stat = stat & ~req.wdata[3:0];
    next_stat = next_stat | ev;
    next_irq = |(next_stat & next_mask);
    next_rdata = 8'h00;
    if (req.rd)
    begin
      case (req.addr)
        tport_pkg::OFS_CTRL: next_rdata = ctrl;
        tport_pkg::OFS_CNT_LO: next_rdata = cnt_lo;
        tport_pkg::OFS_CNT_HI: next_rdata = cnt_hi;
        tport_pkg::OFS_OUT: next_rdata = {2'h0, port};
        tport_pkg::OFS_OE: next_rdata = {2'h0, port_oe};
        tport_pkg::OFS_STAT: next_rdata = {4'h0, stat};
        tport_pkg::OFS_MASK: next_rdata = {4'h0, mask};
        tport_pkg::OFS_SER: next_rdata = {ser_left, 3'h0, ser};
        tport_pkg::OFS_BAUD: next_rdata = baud;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      ctrl <= tport_pkg::CTRL_RST;
      cnt_lo <= 8'h00;
      cnt_hi <= 8'h00;
      port <= 6'h00;
      port_oe <= 6'h00;
      stat <= tport_pkg::ST_RST;
      mask <= tport_pkg::ST_RST;
      rdata <= 8'h00;
      irq <= 1'b0;
      ser_sh <= 8'h00;
      ser_left <= 4'h0;
      ser <= 1'b1;
      baud <= tport_pkg::BAUD_RST;
      gate_prev <= 1'b0;
    end
    else
    begin
      ctrl <= next_ctrl;
      cnt_lo <= next_cnt_lo;
      cnt_hi <= next_cnt_hi;
      port <= next_port;
      port_oe <= next_port_oe;
      stat <= next_stat;
      mask <= next_mask;
      rdata <= next_rdata;
      irq <= next_irq;
      ser_sh <= next_ser_sh;
      ser_left <= next_ser_left;
      ser <= next_ser;
      baud <= next_baud;
      gate_prev <= next_gate_prev;
    end
  end

  assign rdata_o = rdata;
  assign port_o = port;
  assign port_oe_o = port_oe;
  assign ser_o = ser;
  assign irq_o = irq;

  property p_gate_stops;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    gate_fall && !(req.wr && req.addr == tport_pkg::OFS_CTRL)
      |=> ctrl[tport_pkg::CTRL_RUN +: 2] == tport_pkg::RUN_HALT;
  endproperty
  a_gate_stops: assert property (p_gate_stops) else $error("gate did not halt");

  property p_gate_flag;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    gate_fall |=> stat[tport_pkg::ST_GATE];
  endproperty
  a_gate_flag: assert property (p_gate_flag) else $error("gate flag not set");

  property p_wrap;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    ovf_lo && !req.wr |=> cnt_lo == $past(baud);
  endproperty
  a_wrap: assert property (p_wrap) else $error("low counter wrap wrong");

  property p_casc_step;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    ctrl[tport_pkg::CTRL_CASC] && ovf_lo && !req.wr |=> cnt_hi == $past(cnt_hi) + 8'h01;
  endproperty
  a_casc_step: assert property (p_casc_step) else $error("cascade carry lost");

  property p_casc_noflag;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    ctrl[tport_pkg::CTRL_CASC] && !stat[tport_pkg::ST_OVF_LO] |=> !stat[tport_pkg::ST_OVF_LO];
  endproperty
  a_casc_noflag: assert property (p_casc_noflag) else $error("split flag in cascade");

  property p_split_flag;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    !ctrl[tport_pkg::CTRL_CASC] && ovf_lo
      |=> stat[tport_pkg::ST_OVF_LO] && (irq_o || !mask[tport_pkg::ST_OVF_LO]);
  endproperty
  a_split_flag: assert property (p_split_flag) else $error("overflow flag missed");

  property p_rd;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    rd_i && addr_i == tport_pkg::OFS_CNT_LO |=> rdata_o == $past(cnt_lo);
  endproperty
  a_rd: assert property (p_rd) else $error("counter readback wrong");

  property p_wr;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    wr_i && addr_i == tport_pkg::OFS_OE |=> port_oe_o == $past(wdata_i[5:0]);
  endproperty
  a_wr: assert property (p_wr) else $error("enable write lost");

  property p_ser;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    ovf_lo && ser_left != 4'h0 |=> ser_o == $past(ser_sh[0]);
  endproperty
  a_ser: assert property (p_ser) else $error("serial bit wrong");
endmodule // tport_top

// [hw/tport_pkg.sv]
// constants, register map and carrier types for the dual counter timer port
package tport_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CNT_W = 8;
  localparam int unsigned OUT_N = 6;
  // register offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_CNT_LO = 4'h1;
  localparam logic [3:0] OFS_CNT_HI = 4'h2;
  localparam logic [3:0] OFS_OUT = 4'h3;
  localparam logic [3:0] OFS_OE = 4'h4;
  localparam logic [3:0] OFS_STAT = 4'h5;
  localparam logic [3:0] OFS_MASK = 4'h6;
  localparam logic [3:0] OFS_SER = 4'h7;
  localparam logic [3:0] OFS_BAUD = 4'h8;
  // control register fields
  localparam int unsigned CTRL_SEL_LO = 0;   // [1:0] clock source of low counter
  localparam int unsigned CTRL_SEL_HI = 2;   // [3:2] clock source of high counter
  localparam int unsigned CTRL_RUN = 4;      // [5:4] run mode of low counter
  localparam int unsigned CTRL_CASC = 6;     // cascade enable
  localparam int unsigned CTRL_HI_EN = 7;    // high counter enable
  localparam logic [7:0] CTRL_RST = 8'h00;
  // status / mask bit positions
  localparam int unsigned ST_GATE = 0;
  localparam int unsigned ST_OVF_LO = 1;
  localparam int unsigned ST_OVF_HI = 2;
  localparam int unsigned ST_SER = 3;
  localparam logic [3:0] ST_RST = 4'h0;
  localparam logic [7:0] BAUD_RST = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [3:0] SER_BITS = 4'h8;
  // clock source codes
  localparam logic [1:0] SRC_EXT = 2'h0;
  localparam logic [1:0] SRC_ACLK = 2'h1;
  localparam logic [1:0] SRC_MCLK = 2'h2;
  // run modes of the low counter
  localparam logic [1:0] RUN_HALT = 2'h0;
  localparam logic [1:0] RUN_CONT = 2'h1;
  localparam logic [1:0] RUN_GATE_A = 2'h2;
  localparam logic [1:0] RUN_GATE_B = 2'h3;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } bus_req_s;

  typedef struct packed {
    logic ext_lo;
    logic ext_hi;
    logic gate_a;
    logic gate_b;
  } pin_in_s;
endpackage

// [hw/tport_sync.sv]
// three-stage synchroniser with agreement filter for one pin input
`timescale 1ns/10ps
module tport_sync
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // asynchronous level in, filtered level and its rise out
  input wire logic pin_i,
  output logic level_o,
  output logic rise_o
);
  logic [2:0] stage;
  logic level;
  logic [2:0] next_stage;
  logic next_level;

  // first stage feeds only the second; decision uses stages two and three
  always_comb
  begin
    next_stage = {stage[1:0], pin_i};
    next_level = (stage[1] == stage[2]) ? stage[2] : level;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      stage <= 3'h0;
      level <= 1'b0;
    end
    else
    begin
      stage <= next_stage;
      level <= next_level;
    end
  end

  assign level_o = level;
  assign rise_o = next_level & ~level;
endmodule // tport_sync

// [tb/tport_pins.sv]
// pulse and gate sources standing in for the external pins
`timescale 1ns/10ps
module tport_pins
(
  // clock
  input wire logic sys_clk_i,
  // pin levels
  output logic ext_lo_o,
  output logic ext_hi_o,
  output logic gate_a_o,
  output logic gate_b_o
);
  initial
  begin
    ext_lo_o = 1'b0;
    ext_hi_o = 1'b0;
    gate_a_o = 1'b0;
    gate_b_o = 1'b0;
  end
  // six cycles each way so the input filter agrees on every level
  task automatic pulse(input logic hi, input int n);
    repeat (n)
    begin
      if (hi) ext_hi_o <= 1'b1;
      else ext_lo_o <= 1'b1;
      repeat (6) @(posedge sys_clk_i);
      ext_hi_o <= 1'b0;
      ext_lo_o <= 1'b0;
      repeat (6) @(posedge sys_clk_i);
    end
  endtask
  // waits out the pin latency after each change
  task automatic gate(input logic a, input logic b);
    gate_a_o <= a;
    gate_b_o <= b;
    repeat (8) @(posedge sys_clk_i);
  endtask
endmodule // tport_pins

// [tb/tb_top.sv]
// self-checking bench for the dual counter timer port
`timescale 1ns/10ps
module tb_top;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ac = 1'b0;
  logic mc = 1'b0;
  logic [7:0] rdata;
  logic [5:0] port;
  logic [5:0] oe;
  logic ser;
  logic irq;
  logic ext_lo;
  logic ext_hi;
  logic gate_a;
  logic gate_b;
  int failures = 0;
  int n_checks = 0;
  int seed = 67;

  always #20 sys_clk_i = ~sys_clk_i;

  tport_pins tport_pins_i (.sys_clk_i(sys_clk_i), .ext_lo_o(ext_lo), .ext_hi_o(ext_hi),
    .gate_a_o(gate_a), .gate_b_o(gate_b));
  tport_top tport_top_i (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .aclk_tick_i(ac),
    .mclk_tick_i(mc), .ext_lo_i(ext_lo), .ext_hi_i(ext_hi), .gate_a_i(gate_a),
    .gate_b_i(gate_b), .port_o(port), .port_oe_o(oe), .ser_o(ser), .irq_o(irq));

  task automatic conclude;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask

  // gap cycle after each strobe keeps one assignment per time step
  task automatic wrr(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    cyc(1);
    wr <= 1'b0;
    cyc(1);
  endtask

  task automatic rdc(input logic [3:0] a, input logic [7:0] exp, input logic [7:0] m = 8'hff);
    addr <= a;
    rd <= 1'b1;
    cyc(1);
    rd <= 1'b0;
    @(negedge sys_clk_i);
    chk(rdata & m, exp);
    cyc(1);
  endtask

  task automatic seen(input logic [7:0] got_now, input logic [7:0] exp);
    chk(got_now, exp);
  endtask

  task automatic tick(input int k, input int n);
    repeat (n)
    begin
      ac <= (k == 1);
      mc <= (k == 2);
      cyc(1);
      ac <= 1'b0;
      mc <= 1'b0;
      cyc(1);
    end
  endtask

  function automatic logic [7:0] ctrl_w(input logic [1:0] ls, input logic [1:0] hs,
    input logic [1:0] run, input logic c, input logic h);
    logic [7:0] w;
    w = 8'h00;
    w[tport_pkg::CTRL_SEL_LO +: 2] = ls;
    w[tport_pkg::CTRL_SEL_HI +: 2] = hs;
    w[tport_pkg::CTRL_RUN +: 2] = run;
    w[tport_pkg::CTRL_CASC] = c;
    w[tport_pkg::CTRL_HI_EN] = h;
    return w;
  endfunction

  initial
  begin
    repeat (60000) @(posedge sys_clk_i);
    failures++;
    conclude();
  end

  initial
  begin
    logic [7:0] v;
    logic [7:0] w;
    logic [12:0] sv;
    logic ok;
    cyc(12);
    sys_rst_i <= 1'b0;
    @(negedge sys_clk_i);
    seen({7'h00, ser}, 8'h01);
    seen({2'h0, oe}, 8'h00);
    seen({7'h00, irq}, 8'h00);
    cyc(1);
    rdc(tport_pkg::OFS_CTRL, tport_pkg::CTRL_RST);
    rdc(tport_pkg::OFS_STAT, {4'h0, tport_pkg::ST_RST});
    rdc(tport_pkg::OFS_BAUD, tport_pkg::BAUD_RST);
    wrr(4'h9, 8'h5a);
    rdc(4'h9, 8'h00);
    rdc(4'hf, 8'h00);
    rdc(tport_pkg::OFS_CTRL, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 8; i++)
    begin
      v = (i == 0) ? 8'hff : 8'($random(seed));
      w = (i == 0) ? 8'h00 : 8'($random(seed));
      wrr(tport_pkg::OFS_CNT_LO, v);
      wrr(tport_pkg::OFS_CNT_HI, w);
      wrr(tport_pkg::OFS_OUT, v ^ w);
      wrr(tport_pkg::OFS_OE, w);
      rdc(tport_pkg::OFS_CNT_LO, v);
      rdc(tport_pkg::OFS_CNT_HI, w);
      seen({2'h0, port}, (v ^ w) & 8'h3f);
      seen({2'h0, oe}, w & 8'h3f);
    end
    $display("test access done");
    for (int ci = 0; ci < 2; ci++)
      for (int s = 0; s < 3; s++)
      begin
        v = 8'($random(seed));
        if (ci == 1)
          wrr(tport_pkg::OFS_CTRL, ctrl_w(2'h3, 2'(s), tport_pkg::RUN_HALT, 1'b0, 1'b1));
        else
          wrr(tport_pkg::OFS_CTRL, ctrl_w(2'(s), 2'h3, tport_pkg::RUN_CONT, 1'b0, 1'b0));
        wrr((ci == 1) ? tport_pkg::OFS_CNT_HI : tport_pkg::OFS_CNT_LO, v);
        if (s == 0) tport_pins_i.pulse(ci == 1, s + 2);
        else tick(s, s + 2);
        cyc(8);
        rdc((ci == 1) ? tport_pkg::OFS_CNT_HI : tport_pkg::OFS_CNT_LO, v + 8'(s + 2));
      end
    $display("test clock select done");
    wrr(tport_pkg::OFS_STAT, 8'hff);
    wrr(tport_pkg::OFS_CTRL, ctrl_w(tport_pkg::SRC_MCLK, 2'h3, tport_pkg::RUN_CONT, 1'b0, 1'b0));
    wrr(tport_pkg::OFS_CNT_LO, 8'hfe);
    tick(2, 1);
    rdc(tport_pkg::OFS_STAT, 8'h00);
    tick(2, 1);
    rdc(tport_pkg::OFS_STAT, 8'h02);
    seen({7'h00, irq}, 8'h00);
    wrr(tport_pkg::OFS_MASK, 8'h02);
    @(negedge sys_clk_i);
    seen({7'h00, irq}, 8'h01);
    cyc(1);
    wrr(tport_pkg::OFS_STAT, 8'h02);
    @(negedge sys_clk_i);
    seen({7'h00, irq}, 8'h00);
    cyc(1);
    $display("test overflow irq done");
    wrr(tport_pkg::OFS_CTRL, ctrl_w(tport_pkg::SRC_MCLK, 2'h3, tport_pkg::RUN_CONT, 1'b1, 1'b1));
    wrr(tport_pkg::OFS_CNT_LO, 8'hff);
    wrr(tport_pkg::OFS_CNT_HI, 8'h7f);
    tick(2, 1);
    rdc(tport_pkg::OFS_CNT_HI, 8'h80);
    rdc(tport_pkg::OFS_STAT, 8'h00);
    wrr(tport_pkg::OFS_CNT_LO, 8'hff);
    wrr(tport_pkg::OFS_CNT_HI, 8'hff);
    tick(2, 1);
    rdc(tport_pkg::OFS_CNT_LO, 8'h00);
    rdc(tport_pkg::OFS_CNT_HI, 8'h00);
    rdc(tport_pkg::OFS_STAT, 8'h04);
    $display("test cascade done");
    for (int g = 0; g < 2; g++)
    begin
      wrr(tport_pkg::OFS_STAT, 8'hff);
      wrr(tport_pkg::OFS_CNT_LO, 8'h00);
      wrr(tport_pkg::OFS_CTRL, ctrl_w(tport_pkg::SRC_MCLK, 2'h3,
        (g == 1) ? tport_pkg::RUN_GATE_B : tport_pkg::RUN_GATE_A, 1'b0, 1'b0));
      tport_pins_i.gate(g == 1, g == 0);
      tick(2, 2);
      rdc(tport_pkg::OFS_CNT_LO, 8'h00);
      tport_pins_i.gate(g == 0, g == 1);
      tick(2, 3);
      rdc(tport_pkg::OFS_CNT_LO, 8'h03);
      tport_pins_i.gate(1'b0, 1'b0);
      rdc(tport_pkg::OFS_STAT, 8'h01);
      rdc(tport_pkg::OFS_CTRL, ctrl_w(tport_pkg::SRC_MCLK, 2'h3, 2'h0, 1'b0, 1'b0));
      tick(2, 2);
      rdc(tport_pkg::OFS_CNT_LO, 8'h03);
    end
    $display("test gate done");
    wrr(tport_pkg::OFS_STAT, 8'hff);
    wrr(tport_pkg::OFS_BAUD, 8'hff);
    wrr(tport_pkg::OFS_CNT_LO, 8'hff);
    wrr(tport_pkg::OFS_CTRL, ctrl_w(tport_pkg::SRC_MCLK, 2'h3, tport_pkg::RUN_CONT, 1'b0, 1'b0));
    v = 8'($random(seed));
    wrr(tport_pkg::OFS_SER, v);
    // first bit leaves on the first overflow after the load
    for (int i = 0; i < 13; i++)
    begin
      @(negedge sys_clk_i);
      sv[i] = ser;
      cyc(1);
      tick(2, 1);
      cyc(2);
    end
    ok = (sv[8:1] === v);
    seen({7'h00, ok}, 8'h01);
    seen({7'h00, sv[0]}, 8'h01);
    rdc(tport_pkg::OFS_STAT, 8'h08, 8'h08);
    @(negedge sys_clk_i);
    // line keeps the last bit once the frame is out
    seen({7'h00, ser}, {7'h00, v[7]});
    $display("test serial done");
    cyc(1);
    conclude();
  end
endmodule // tb_top
